/* File: core/upsf_power_fsm.sv */
/*
  Power-state controller of a USB charging port: Sleep, Detect, Active, Error.
  Assumes all control and comparator inputs are asynchronous levels from pins
  or analog blocks; attach, removal and error-clear are level pulses that the
  detector holds for at least two clock cycles.
*/
`timescale 1ns/1ps
module upsf_power_fsm #(
  parameter int DISCHARGE_CNT = upsf_pkg::DISCHARGE_CYCLES,
  parameter int MASK_CNT = upsf_pkg::MASK_CYCLES,
  parameter int RETRY_CNT = upsf_pkg::RETRY_CYCLES,
  parameter int BLINK_CNT = upsf_pkg::BLINK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire upsf_pkg::upsf_ctrl_s ctrl,
  input wire upsf_pkg::upsf_fault_s fault,
  input wire logic attach_event,
  input wire logic removal_event,
  input wire logic bypass_overload,
  input wire logic error_clear,
  output upsf_pkg::upsf_switch_s switches,
  output upsf_pkg::upsf_state_e power_state,
  output logic [2:0] active_mode,
  output logic mode_start,
  output logic back_voltage_flag,
  output logic alert_out,
  output logic alert_oe_n,
  output logic attach_indicator_out,
  output logic attach_indicator_oe_n
);
  import upsf_pkg::*;

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  if (DISCHARGE_CNT < 1)
  begin : g_bad_discharge
    $error("upsf_power_fsm: DISCHARGE_CNT must be at least one");
  end

  if (MASK_CNT < 1)
  begin : g_bad_mask
    $error("upsf_power_fsm: MASK_CNT must be at least one");
  end

  if (RETRY_CNT < 1)
  begin : g_bad_retry
    $error("upsf_power_fsm: RETRY_CNT must be at least one");
  end

  if (BLINK_CNT < 1)
  begin : g_bad_blink
    $error("upsf_power_fsm: BLINK_CNT must be at least one");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_live;
  logic [SYNC_W-1:0] sync_prev;
  wire [SYNC_W-1:0] raw_in = {ctrl, fault, attach_event, removal_event, bypass_overload, error_clear};

  // flushed to zero: a level already high at release reads as one edge
  // two-flop crossing
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync_meta <= '0;
      sync_live <= '0;
      sync_prev <= '0;
    end
    else
    begin
      sync_meta <= raw_in;
      sync_live <= sync_meta;
      sync_prev <= sync_live;
    end
  end

  wire upsf_ctrl_s c = upsf_ctrl_s'(sync_live[SYNC_W-1 -: 6]);
  wire upsf_fault_s f = upsf_fault_s'(sync_live[11:4]);
  wire attach_edge = sync_live[3] & ~sync_prev[3];
  wire removal_edge = sync_live[2] & ~sync_prev[2];
  wire overload = sync_live[1];
  wire clear_edge = sync_live[0] & ~sync_prev[0];
  wire pe_prev = sync_prev[SYNC_W-2];
  // any change of power enable counts, rising or falling
  wire pe_toggle = c.port_power_enable ^ pe_prev;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // saturating interval counter; cleared whenever its condition is absent
  function automatic logic [CNT_W-1:0] upsf_count(input logic run, input logic [CNT_W-1:0] cnt);
    if (!run)
      return '0;
    else if (cnt == '1)
      return cnt;
    else
      return cnt + CNT_W'(1);
  endfunction : upsf_count

  // limit given as int so package constants pass without a cast
  function automatic logic upsf_reached(input logic [CNT_W-1:0] cnt, input int limit);
    return cnt >= CNT_W'(limit);
  endfunction : upsf_reached

  // ----------------------------------------
  // state and decode
  // ----------------------------------------
  upsf_state_e state;
  upsf_state_e next_state;
  logic attached;
  logic next_attached;
  logic [CNT_W-1:0] timer;
  logic [CNT_W-1:0] bvs_cnt;
  logic [CNT_W-1:0] bvc_cnt;
  logic [CNT_W-1:0] sov_cnt;
  logic [CNT_W-1:0] blink_cnt;

  wire mode_nonzero = c.mode_select_first | c.mode_select_second | c.emulation_enable;
  wire source_ok = ~f.source_undervoltage;
  wire bv_any = f.back_voltage_source | f.back_voltage_core;
  wire active_allowed = c.port_power_enable & mode_nonzero & source_ok
    & (~c.attach_detect_enable | attached);
  wire want_sleep = ~c.attach_detect_enable & (~c.port_power_enable | ~mode_nonzero);
  // automatic attach with attach detect, power enable and a mode already set, source present
  wire auto_attach = attach_edge & c.attach_detect_enable & c.port_power_enable & mode_nonzero & source_ok;
  wire in_active = state == ST_ACTIVE;

  // source back-voltage becomes a fault once held for MASK_CNT cycles, in any state
  wire bvs_expired = upsf_reached(bvs_cnt, MASK_CNT);
  // core back-voltage becomes a fault once held for MASK_CNT cycles, in any state
  wire bvc_expired = upsf_reached(bvc_cnt, MASK_CNT);
  wire sov_expired = upsf_reached(sov_cnt, MASK_CNT);

  wire active_fault = f.thermal_shutdown | f.overcurrent | f.bus_undervoltage | f.discharge_error
    | sov_expired | bvs_expired | bvc_expired;
  // only back-drive or thermal sends Detect to Error
  wire detect_fault = f.thermal_shutdown | bvs_expired | bvc_expired;
  wire sleep_fault = bvs_expired | bvc_expired;
  wire any_fault = f.thermal_shutdown | f.overcurrent | f.bus_undervoltage | f.discharge_error
    | f.source_overvoltage | bv_any;

  // latching restart by clear or power enable toggle
  wire latch_restart = c.latch_mode & (clear_edge | pe_toggle);
  wire retry_done = ~c.latch_mode & upsf_reached(timer, RETRY_CNT);

  // where a clean check or a dropped enabling condition lands
  upsf_state_e settle_state;
  assign settle_state = want_sleep ? ST_SLEEP : (active_allowed ? ST_BYPASS_OFF : ST_DETECT);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_SLEEP:
        if (sleep_fault)
          next_state = ST_ERROR;
        else if (!want_sleep)
          next_state = settle_state;
      ST_DETECT:
        if (detect_fault)
          next_state = ST_ERROR;
        else if (auto_attach || active_allowed)
          next_state = ST_BYPASS_OFF;
        else if (want_sleep)
          next_state = ST_SLEEP;
      ST_BYPASS_OFF:
        next_state = ST_DISCHARGE;
      ST_DISCHARGE:
        if (detect_fault)
          next_state = ST_ERROR;
        // port closes only after the full discharge pulse
        else if (upsf_reached(timer, DISCHARGE_CNT))
          next_state = active_allowed ? ST_ACTIVE : settle_state;
      ST_ACTIVE:
        if (active_fault)
          next_state = ST_ERROR;
        // leave Active once any enabling condition drops
        else if (!active_allowed)
          next_state = settle_state;
      ST_ERROR:
        if (removal_edge || latch_restart || retry_done)
          next_state = ST_CHECK;
      ST_CHECK:
        // return only when every condition has gone
        next_state = any_fault ? ST_ERROR : settle_state;
      default:
        // an unused code falls back to the safest state
        next_state = ST_SLEEP;
    endcase
  end

  // ----------------------------------------
  // attach tracking
  // ----------------------------------------
  always_comb
  begin
    next_attached = attached;
    // removal wins over an attach seen in the same cycle
    if (state == ST_SLEEP || !c.attach_detect_enable || removal_edge)
      next_attached = 1'b0;
    // attach detection only while waiting in Detect
    else if (state == ST_DETECT && attach_edge)
      next_attached = 1'b1;
  end

  // ----------------------------------------
  // switch and indicator decode
  // ----------------------------------------
  upsf_switch_s next_switches;
  logic next_alert;
  logic next_attach_ind;
  logic next_blink;
  logic blink;

  wire port_path = next_state == ST_ACTIVE;
  wire bypass_path = next_state == ST_DETECT;
  wire active_entry = next_state == ST_ACTIVE && state != ST_ACTIVE;

  always_comb
  begin
    next_switches = '0;
    // back-voltage overrides every state so the bypass, port and data switches open at once; discharge is not gated
    // Detect feeds the bus from the core supply
    next_switches.bypass = bypass_path & ~bv_any;
    // port closed in Active; opened at once on back-voltage
    // overvoltage opens the port only through Error, once masked
    next_switches.port_power = port_path & ~bv_any;
    // discharge pulse between bypass off and port on
    next_switches.discharge = next_state == ST_DISCHARGE;
    // data path closed only in Active; mode decode may open it downstream
    next_switches.hs_data = port_path & ~bv_any;
    // Error and Sleep leave every switch open
    if (next_state == ST_ERROR || next_state == ST_CHECK || next_state == ST_SLEEP)
      next_switches = '0;
  end

  // alert holds through Check so a failed check never releases the pin
  // alert on Error entry; released when Check passes
  assign next_alert = (next_state == ST_ERROR) | (next_state == ST_CHECK) |
    (alert_out == 1'b0 && alert_oe_n == 1'b0 && next_state != ST_SLEEP && state != ST_CHECK);

  // toggling while overload on bypass path with source absent
  wire blink_run = c.attach_detect_enable & c.port_power_enable & f.source_undervoltage & overload;
  assign next_blink = blink_run ? (upsf_reached(blink_cnt, BLINK_CNT) ? ~blink : blink) : 1'b0;

  // asserted from attach until removal or attach detect disable; also in Active with attach detection off
  assign next_attach_ind = (next_attached | (~c.attach_detect_enable & port_path)) ^ next_blink;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state <= ST_SLEEP;
      attached <= 1'b0;
      timer <= '0;
    end
    else
    begin
      state <= next_state;
      attached <= next_attached;
      // one timer serves discharge and retry; restarts on each state change
      timer <= upsf_count(next_state == state, timer);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      bvs_cnt <= '0;
      bvc_cnt <= '0;
      sov_cnt <= '0;
      blink_cnt <= '0;
      blink <= 1'b0;
    end
    else
    begin
      bvs_cnt <= upsf_count(f.back_voltage_source, bvs_cnt);
      bvc_cnt <= upsf_count(f.back_voltage_core, bvc_cnt);
      // counted only in Active: elsewhere the port is open already
      sov_cnt <= upsf_count(f.source_overvoltage & in_active, sov_cnt);
      // restarts at each toggle so every half period is equal
      blink_cnt <= upsf_count(blink_run & ~upsf_reached(blink_cnt, BLINK_CNT), blink_cnt);
      blink <= next_blink;
    end
  end

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      switches <= '0;
      power_state <= ST_SLEEP;
      active_mode <= '0;
      mode_start <= 1'b0;
      back_voltage_flag <= 1'b0;
      alert_out <= 1'b0;
      alert_oe_n <= 1'b1;
      attach_indicator_out <= 1'b0;
      attach_indicator_oe_n <= 1'b1;
    end
    else
    begin
      switches <= next_switches;
      power_state <= next_state;
      // mode restarts on every entry to Active
      mode_start <= active_entry;
      if (active_entry)
        active_mode <= {c.emulation_enable, c.mode_select_second, c.mode_select_first};
      back_voltage_flag <= bv_any;
      alert_out <= 1'b0;
      alert_oe_n <= ~next_alert;
      attach_indicator_out <= 1'b0;
      attach_indicator_oe_n <= ~next_attach_ind;
    end
  end

endmodule : upsf_power_fsm

/* File: inc/upsf_pkg.sv */
/*
  Shared types and constants for the USB port power-state controller.
  Assumes a single 200 MHz system clock and pin-level control inputs.
*/
package upsf_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DISCHARGE_PULSE_TIME_US = 200;
  localparam int FAULT_MASK_TIME_US = 5;
  localparam int AUTO_RETRY_PERIOD_MS = 100;
  localparam int ATTACH_BLINK_TIME_US = 10;
  // least times round up
  localparam int DISCHARGE_CYCLES =
    (DISCHARGE_PULSE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MASK_CYCLES = (FAULT_MASK_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RETRY_CYCLES = (AUTO_RETRY_PERIOD_MS * 1000 / CLK_PERIOD_PS) * 1000000;
  localparam int BLINK_CYCLES = (ATTACH_BLINK_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 32;
  localparam int SYNC_W = 18;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_SLEEP, ST_DETECT, ST_BYPASS_OFF, ST_DISCHARGE, ST_ACTIVE, ST_ERROR, ST_CHECK
  } upsf_state_e;

  typedef struct packed {
    logic attach_detect_enable;
    logic port_power_enable;
    logic mode_select_first;
    logic mode_select_second;
    logic emulation_enable;
    logic latch_mode;
  } upsf_ctrl_s;

  typedef struct packed {
    logic thermal_shutdown;
    logic overcurrent;
    logic bus_undervoltage;
    logic discharge_error;
    logic source_overvoltage;
    logic source_undervoltage;
    logic back_voltage_source;
    logic back_voltage_core;
  } upsf_fault_s;

  typedef struct packed {
    logic port_power;
    logic bypass;
    logic discharge;
    logic hs_data;
  } upsf_switch_s;

endpackage : upsf_pkg

/* File: verification/upsf_host_model.sv */
/*
  Model of the host pins and the attached portable device: a one-cycle kick
  becomes an event level three cycles long.
  Assumes the bench kicks on the rising edge and spaces kicks apart.
*/
`timescale 1ns/1ps
module upsf_host_model (
  input wire logic clk_sys,
  input wire logic [2:0] kick,
  output logic [2:0] ev = 3'h0
);
  logic [2:0] kick_d1 = 3'h0;
  logic [2:0] kick_d2 = 3'h0;
  // host event timing
  // three cycles high: the detector wants two samples, one spare for phase
  always @(posedge clk_sys)
  begin
    kick_d1 <= kick;
    kick_d2 <= kick_d1;
    ev <= kick | kick_d1 | kick_d2;
  end
endmodule : upsf_host_model

/* File: verification/upsf_power_fsm_chk.sv */
/*
  Assertions on the outputs of the power-state controller.
  Assumes it is bound to upsf_power_fsm and sees only its ports.
*/
`timescale 1ns/1ps
module upsf_power_fsm_chk #(
  parameter int DISCHARGE_CNT = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire upsf_pkg::upsf_switch_s switches,
  input wire upsf_pkg::upsf_state_e power_state,
  input wire logic mode_start,
  input wire logic back_voltage_flag,
  input wire logic alert_oe_n,
  input wire logic attach_indicator_oe_n
);
  import upsf_pkg::*;
  logic [31:0] dis_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // discharge length counter
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    dis_cnt <= (reset || !switches.discharge) ? 32'h0 : dis_cnt + 32'h1;
  end
  chk_detect_switches: assert property (power_state == ST_DETECT |-> !switches.port_power && !switches.hs_data)
    else $error("port or data switch closed in detect");
  chk_discharge_first: assert property ($rose(switches.discharge) |-> !switches.bypass && !switches.port_power)
    else $error("discharge began with a supply switch closed");
  chk_discharge_len: assert property ($fell(switches.discharge) |-> dis_cnt == DISCHARGE_CNT + 1)
    else $error("discharge pulse length wrong");
  chk_port_active: assert property (switches.port_power |-> power_state == ST_ACTIVE || $past(power_state) == ST_ACTIVE)
    else $error("port switch closed outside active");
  chk_mode_pulse: assert property ($rose(power_state == ST_ACTIVE) |-> ##[0:1] mode_start ##1 !mode_start)
    else $error("mode start missing or too long");
  chk_error_open: assert property (power_state == ST_ERROR && $past(power_state) == ST_ERROR |-> switches == 4'h0 && !alert_oe_n)
    else $error("error state with switch closed or alert released");
  chk_backv_open: assert property (back_voltage_flag && $past(back_voltage_flag) |-> !switches.port_power && !switches.bypass && !switches.hs_data)
    else $error("switch closed during back voltage");
  chk_sleep_idle: assert property (power_state == ST_SLEEP && $past(power_state) == ST_SLEEP |-> switches == 4'h0 && alert_oe_n && attach_indicator_oe_n)
    else $error("sleep with switch closed or pin asserted");
endmodule : upsf_power_fsm_chk

/* File: verification/upsf_power_fsm_bench.sv */
/*
  Self-checking bench of the USB port power-state controller.
  Assumes shortened counts; attach, removal and clear come from the host model.
*/
`timescale 1ns/1ps
module upsf_power_fsm_bench;
  import upsf_pkg::*;
  localparam int DIS = 8;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  upsf_ctrl_s ctrl = '0;
  upsf_fault_s fault = '0;
  logic bypass_overload = 1'b0;
  logic [2:0] kick = 3'h0;
  logic [2:0] ev;
  upsf_switch_s switches;
  upsf_state_e power_state;
  logic [2:0] active_mode;
  logic mode_start, back_voltage_flag, alert_out, alert_oe_n, attach_indicator_out, attach_indicator_oe_n;
  int fails = 0;
  int checks = 0;
  logic seen_ind;
  always #2.5 clk_sys = ~clk_sys;
  upsf_host_model upsf_host_model_i (.clk_sys(clk_sys), .kick(kick), .ev(ev));
  // mask kept long so a short back-voltage blip can be cleared in time
  upsf_power_fsm #(.DISCHARGE_CNT(DIS), .MASK_CNT(12), .RETRY_CNT(16), .BLINK_CNT(4)) upsf_power_fsm_i (
    .clk_sys(clk_sys), .reset(reset), .ctrl(ctrl), .fault(fault), .attach_event(ev[0]),
    .removal_event(ev[1]), .bypass_overload(bypass_overload), .error_clear(ev[2]), .switches(switches),
    .power_state(power_state), .active_mode(active_mode), .mode_start(mode_start),
    .back_voltage_flag(back_voltage_flag), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
    .attach_indicator_out(attach_indicator_out), .attach_indicator_oe_n(attach_indicator_oe_n));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // outputs are sampled on the falling edge, well clear of the updates
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : step
  task automatic await(input upsf_state_e s, input int lim);
    for (int i = 0; i < lim && power_state !== s; i++)
      @(negedge clk_sys);
    check(power_state, s);
  endtask : await
  task automatic pulse(input int i);
    @(posedge clk_sys) kick <= 3'h1 << i;
    @(posedge clk_sys) kick <= 3'h0;
    step(6);
  endtask : pulse
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    step(12);
    @(posedge clk_sys) reset <= 1'b0;
    step(4);
    check(switches, 4'h0);
    @(posedge clk_sys) ctrl <= 6'h38;
    await(ST_DETECT, 20);
    check(switches, 4'h4);
    pulse(0);
    await(ST_DISCHARGE, 20);
    check(switches, 4'h2);
    await(ST_ACTIVE, DIS + 10);
    check(switches, 4'h9);
    check(active_mode, 3'h1);
    check(attach_indicator_oe_n, 1'b0);
    @(posedge clk_sys) fault <= 8'h02;
    step(5);
    check(switches, 4'h0);
    @(posedge clk_sys) fault <= 8'h00;
    step(6);
    check(switches, 4'h9);
    check(power_state, ST_ACTIVE);
    @(posedge clk_sys) ctrl.attach_detect_enable <= 1'b0;
    @(posedge clk_sys) fault.source_overvoltage <= 1'b1;
    step(5);
    check(switches, 4'h9);
    await(ST_ERROR, 40);
    check(switches, 4'h0);
    check(alert_oe_n, 1'b0);
    check(alert_out, 1'b0);
    check(attach_indicator_out, 1'b0);
    @(posedge clk_sys) fault.source_overvoltage <= 1'b0;
    step(8);
    check(power_state, ST_ERROR);
    await(ST_ACTIVE, 60);
    @(posedge clk_sys) ctrl <= 6'h2F;
    await(ST_DETECT, 20);
    pulse(0);
    step(10);
    check(power_state, ST_DETECT);
    @(posedge clk_sys) ctrl.port_power_enable <= 1'b1;
    await(ST_ACTIVE, 40);
    check(active_mode, 3'h7);
    @(posedge clk_sys) fault.bus_undervoltage <= 1'b1;
    await(ST_ERROR, 20);
    @(posedge clk_sys) fault.bus_undervoltage <= 1'b0;
    step(30);
    check(power_state, ST_ERROR);
    pulse(1);
    await(ST_DETECT, 20);
    check(attach_indicator_oe_n, 1'b1);
    @(posedge clk_sys) fault <= 8'h04;
    bypass_overload <= 1'b1;
    step(4);
    seen_ind = attach_indicator_oe_n;
    step(5);
    check(attach_indicator_oe_n, !seen_ind);
    step(5);
    check(attach_indicator_oe_n, seen_ind);
    @(posedge clk_sys) bypass_overload <= 1'b0;
    @(posedge clk_sys) fault <= 8'h40;
    step(10);
    check(power_state, ST_DETECT);
    @(posedge clk_sys) fault <= 8'h01;
    step(5);
    check(back_voltage_flag, 1'b1);
    check(switches, 4'h0);
    @(posedge clk_sys) fault <= 8'h00;
    step(6);
    check(switches, 4'h4);
    @(posedge clk_sys) fault <= 8'h01;
    await(ST_ERROR, 40);
    @(posedge clk_sys) fault <= 8'h00;
    step(4);
    pulse(2);
    await(ST_DETECT, 20);
    @(posedge clk_sys) ctrl <= '0;
    await(ST_SLEEP, 20);
    check(alert_oe_n, 1'b1);
    @(posedge clk_sys) fault <= 8'h80;
    step(10);
    check(power_state, ST_SLEEP);
    @(posedge clk_sys) fault <= 8'h02;
    await(ST_ERROR, 40);
    check(alert_oe_n, 1'b0);
    @(posedge clk_sys) fault <= 8'h00;
    await(ST_SLEEP, 60);
    check(alert_oe_n, 1'b1);
    summarize();
  end
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    fails++;
    summarize();
  end
endmodule : upsf_power_fsm_bench
bind upsf_power_fsm upsf_power_fsm_chk #(.DISCHARGE_CNT(DISCHARGE_CNT)) upsf_power_fsm_chk_i (.clk_sys, .reset,
  .switches, .power_state, .mode_start, .back_voltage_flag, .alert_oe_n, .attach_indicator_oe_n);
